// >>> logic/tmq_train_tx.sv
// Office-end training transmitter: message builder, tone mapper, quadrant scrambler
//
// Functional notes
// - Update message goes once; resent only on a repeat request from the far end.
// - Gain field: one count octet, then one three-octet group per tone.
// - In each group bits 0-11 hold tone index, bits 12-23 the gain.
// - Gain is signed two's complement in quarter-dB amplification steps.
// - Last field is a signed 16-bit timing advance correction in samples.
// - Extension message carries code then two-byte final extension length.
// - Extension message goes once; resent only on a repeat request.
// - Final extension length takes effect at start of channel analysis.
// - Training symbols sent throughout training; sync symbol marks its end.
// - Training symbol uses every allowed tone in 4QAM, length N plus extension.
// - One byte per symbol; tones 10n+1..7 carry bit pairs, others zero.
// - Each point rotated per its two scrambler bits in quarter turns.
// - Tone zero never rotated; its scrambler pair forced to zero.
// - Each scrambler bit is XOR of bits nine and eleven steps earlier.
// - 2N scrambler bits per symbol, pair j to tone j, all tones.
// - Scrambler starts all ones and reloads each training symbol.
// - In channel analysis scrambler runs on, skipping four bits between symbols.
`timescale 1ns/1ps
module tmq_train_tx
    import tmq_pkg::*;
#(
    parameter int N_TONES = 64,
    parameter int MAX_TONES = TMQ_MAX_TONES,
    parameter int FIFO_DEPTH = 4,
    parameter logic [7:0] UPDATE_CODE = 8'h5a, // Message codes: arbitrary values
    parameter logic [7:0] FINAL_CODE = 8'ha5
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Phase control from the training sequencer
    input wire logic i_train_start,
    input wire logic i_sync_start,
    input wire logic i_analysis_start,
    // Update message content
    input wire logic i_upd_send,
    input wire logic i_upd_repeat,
    input wire logic [$clog2(MAX_TONES+1)-1:0] i_upd_count,
    input wire logic [MAX_TONES*TMQ_TONE_W-1:0] i_upd_tones,
    input wire logic [MAX_TONES*TMQ_GAIN_W-1:0] i_upd_gains,
    input wire logic [15:0] i_upd_timing_adv,
    // Final extension message content
    input wire logic i_fin_send,
    input wire logic i_fin_repeat,
    input wire logic [15:0] i_fin_ce_len,
    input wire logic [15:0] i_init_ce_len,
    // Symbol strobe from the sample engine
    input wire logic i_sym_start,
    input wire logic i_tone_ready,
    // Tone stream out
    output logic o_tone_valid,
    output logic [TMQ_TONE_W-1:0] o_tone_idx,
    output logic o_tone_x_neg,
    output logic o_tone_y_neg,
    output logic o_sym_last,
    output logic o_msg_busy,
    output logic [1:0] o_phase,
    output logic [15:0] o_ce_len
);
    localparam int CW = $clog2(MAX_TONES+1);
    localparam int TW = TMQ_TONE_W;
    localparam logic [TW-1:0] LAST_TONE = TW'(N_TONES - 1);
    localparam logic [2:0] SKIP_LAST = 3'(TMQ_SKIP_BITS/2 - 1);
    localparam logic [3:0] PERIOD = 4'(TMQ_TONE_PERIOD);
    localparam logic [3:0] PAD_SLOT = 4'(TMQ_TONE_PAD);

    // Reset synchroniser: first stage read only by the second
    logic rst_meta;
    logic rst_b;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta <= 1'b0;
            rst_b <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_b <= rst_meta;
        end
    end

    // Phase register
    tmq_phase_e phase;
    always_ff @(posedge i_ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            phase <= TMQ_PH_IDLE;
        else if (i_analysis_start)
            phase <= TMQ_PH_ANALYSIS;
        else if (i_sync_start && phase == TMQ_PH_TRAIN)
            phase <= TMQ_PH_SYNC;
        else if (i_train_start)
            phase <= TMQ_PH_TRAIN;
    end
    assign o_phase = phase;

    // Message builder: latched count and tail, live group words, byte sequencing
    tmq_msg_e mstate;
    logic is_update;
    logic [CW-1:0] grp_total;
    logic [CW-1:0] grp_idx;
    logic [1:0] oct_idx;
    logic [15:0] tail;
    logic [15:0] fin_len;
    logic [15:0] ce_len;
    logic [7:0] msg_byte;
    logic byte_valid;
    wire byte_ready;

    // Current group word: tone in bits 0-11, gain in 12-23
    wire [TW-1:0] grp_tone = i_upd_tones[grp_idx*TW +: TW];
    wire [TMQ_GAIN_W-1:0] grp_gain = i_upd_gains[grp_idx*TMQ_GAIN_W +: TMQ_GAIN_W];
    wire [23:0] grp_word = {grp_gain, grp_tone};
    wire [7:0] grp_octet = grp_word[oct_idx*8 +: 8];
    wire start_upd = (i_upd_send || i_upd_repeat) && phase == TMQ_PH_TRAIN;
    wire start_fin = (i_fin_send || i_fin_repeat) && phase == TMQ_PH_TRAIN;
    wire take = byte_valid && byte_ready;

    assign o_msg_busy = (mstate != TMQ_MS_IDLE);

    // Byte selection for the current message step
    always_comb
    begin
        msg_byte = TMQ_IDLE_BYTE;
        case (mstate)
            TMQ_MS_CODE: msg_byte = is_update ? UPDATE_CODE : FINAL_CODE;
            TMQ_MS_COUNT: msg_byte = 8'(grp_total);
            TMQ_MS_GROUP: msg_byte = grp_octet;
            TMQ_MS_TAIL_HI: msg_byte = tail[7:0]; // ascending octets
            TMQ_MS_TAIL_LO: msg_byte = tail[15:8];
            default: msg_byte = TMQ_IDLE_BYTE;
        endcase
    end
    assign byte_valid = (mstate != TMQ_MS_IDLE);

    // Message sequencing; a message is only sent on an explicit request
    always_ff @(posedge i_ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mstate <= TMQ_MS_IDLE;
            is_update <= 1'b0;
            grp_total <= '0;
            grp_idx <= '0;
            oct_idx <= '0;
            tail <= 16'h0000;
        end
        else
        begin
            case (mstate)
                TMQ_MS_IDLE:
                begin
                    grp_idx <= '0;
                    oct_idx <= '0;
                    if (start_upd)
                    begin
                        mstate <= TMQ_MS_CODE;
                        is_update <= 1'b1;
                        grp_total <= i_upd_count;
                        tail <= i_upd_timing_adv;
                    end
                    else if (start_fin)
                    begin
                        mstate <= TMQ_MS_CODE;
                        is_update <= 1'b0;
                        tail <= i_fin_ce_len;
                    end
                end
                TMQ_MS_CODE:
                    if (take)
                        mstate <= is_update ? TMQ_MS_COUNT : TMQ_MS_TAIL_HI;
                TMQ_MS_COUNT:
                    if (take)
                        mstate <= (grp_total == '0) ? TMQ_MS_TAIL_HI : TMQ_MS_GROUP;
                TMQ_MS_GROUP:
                    if (take)
                    begin
                        if (oct_idx == 2'(TMQ_GROUP_OCTETS - 1))
                        begin
                            oct_idx <= '0;
                            grp_idx <= grp_idx + 1'b1;
                            if (grp_idx + 1'b1 == grp_total)
                                mstate <= TMQ_MS_TAIL_HI;
                        end
                        else
                            oct_idx <= oct_idx + 1'b1;
                    end
                TMQ_MS_TAIL_HI:
                    if (take)
                        mstate <= TMQ_MS_TAIL_LO;
                TMQ_MS_TAIL_LO:
                    if (take)
                        mstate <= TMQ_MS_IDLE;
                default: mstate <= TMQ_MS_IDLE;
            endcase
        end
    end

    // Final extension length held until channel analysis begins
    always_ff @(posedge i_ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fin_len <= 16'h0000;
            ce_len <= 16'h0000;
        end
        else
        begin
            if (mstate == TMQ_MS_IDLE && start_fin && !start_upd)
                fin_len <= i_fin_ce_len;
            if (i_analysis_start)
                ce_len <= fin_len;
            else if (i_train_start)
                ce_len <= i_init_ce_len;
        end
    end
    assign o_ce_len = ce_len;

    // Byte FIFO decouples message building from symbol pace
    logic sym_byte_valid;
    logic [7:0] sym_byte;
    logic byte_pop;
    tmq_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_ref_clk),
        .i_rst_b(rst_b),
        .i_in_valid(byte_valid),
        .o_in_ready(byte_ready),
        .i_in_data(msg_byte),
        .o_out_valid(sym_byte_valid),
        .i_out_ready(byte_pop),
        .o_out_data(sym_byte)
    );

    // Symbol walker: one tone per cycle, skip steps between analysis symbols
    logic active;
    logic skipping;
    logic [2:0] skip_cnt;
    logic [TW-1:0] tone;
    logic [3:0] slot;
    logic [7:0] cur_byte;
    logic [1:0] sc_bits;
    wire tone_go = active && !skipping && i_tone_ready;
    wire last_tone = tone == LAST_TONE;
    wire new_sym = i_sym_start && !active && phase != TMQ_PH_IDLE;
    wire reload = (new_sym && phase != TMQ_PH_ANALYSIS) || i_analysis_start;
    wire sc_step = tone_go || skipping;
    assign byte_pop = new_sym && phase == TMQ_PH_TRAIN && sym_byte_valid;

    tmq_scrambler u_scr (
        .i_clk(i_ref_clk),
        .i_rst_b(rst_b),
        .i_reload(reload),
        .i_step(sc_step),
        .o_bits(sc_bits)
    );

    always_ff @(posedge i_ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            active <= 1'b0;
            skipping <= 1'b0;
            skip_cnt <= '0;
            tone <= '0;
            slot <= '0;
            cur_byte <= TMQ_IDLE_BYTE;
        end
        else
        begin
            if (new_sym)
            begin
                active <= 1'b1;
                tone <= '0;
                slot <= '0;
                // Sync symbol carries a fixed pattern, not message data
                if (phase == TMQ_PH_TRAIN)
                    cur_byte <= sym_byte_valid ? sym_byte : TMQ_IDLE_BYTE;
                else
                    cur_byte <= TMQ_IDLE_BYTE;
            end
            else if (tone_go)
            begin
                tone <= tone + 1'b1;
                slot <= (slot == PERIOD - 4'h1) ? 4'h0 : slot + 4'h1;
                if (last_tone)
                begin
                    active <= 1'b0;
                    skipping <= (phase == TMQ_PH_ANALYSIS);
                    skip_cnt <= '0;
                end
            end
            else if (skipping)
            begin
                skip_cnt <= skip_cnt + 3'h1;
                if (skip_cnt == SKIP_LAST)
                    skipping <= 1'b0;
            end
        end
    end

    // Tone mapping: pairs on odd slots below the pad slot
    wire odd_slot = slot[0] && slot != PAD_SLOT;
    wire [1:0] data_pair = cur_byte[slot[3:1]*2 +: 2];
    wire [1:0] point = odd_slot ? data_pair : TMQ_POINT_ZERO;
    wire [1:0] rot = (tone == '0) ? TMQ_POINT_ZERO : {sc_bits[0], sc_bits[1]};
    // Quadrant point: bit0 sets X sign, bit1 sets Y sign
    wire x0 = point[0];
    wire y0 = point[1];
    logic next_xn;
    logic next_yn;
    always_comb
    begin
        next_xn = x0;
        next_yn = y0;
        case (rot)
            TMQ_POINT_ZERO:
            begin
                next_xn = x0;
                next_yn = y0;
            end
            TMQ_ROT_90:
            begin
                next_xn = !y0; // (-Y, X)
                next_yn = x0;
            end
            TMQ_ROT_180:
            begin
                next_xn = !x0; // (-X, -Y)
                next_yn = !y0;
            end
            TMQ_ROT_270:
            begin
                next_xn = y0; // (Y, -X)
                next_yn = !x0;
            end
            default:
            begin
                next_xn = x0;
                next_yn = y0;
            end
        endcase
    end

    // Registered tone output; every tone is emitted, allowed or not
    always_ff @(posedge i_ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            o_tone_valid <= 1'b0;
            o_tone_idx <= '0;
            o_tone_x_neg <= 1'b0;
            o_tone_y_neg <= 1'b0;
            o_sym_last <= 1'b0;
        end
        else
        begin
            o_tone_valid <= tone_go;
            o_tone_idx <= tone;
            o_tone_x_neg <= next_xn;
            o_tone_y_neg <= next_yn;
            o_sym_last <= tone_go && last_tone;
        end
    end
endmodule : tmq_train_tx

// >>> logic/tmq_pkg.sv
// Package of constants for the training message and quadrant scrambler block
package tmq_pkg;
    localparam int TMQ_LFSR_W = 11;
    localparam logic [10:0] TMQ_LFSR_SEED = 11'h7ff;
    localparam int TMQ_TAP_A = 8;
    localparam int TMQ_TAP_B = 10;
    localparam int TMQ_SKIP_BITS = 4;
    localparam int TMQ_TONE_W = 12;
    localparam int TMQ_GAIN_W = 12;
    localparam int TMQ_MAX_TONES = 16;
    localparam int TMQ_GROUP_OCTETS = 3;
    localparam int TMQ_TONE_PERIOD = 10;
    localparam int TMQ_TONE_PAD = 9;
    localparam logic [1:0] TMQ_POINT_ZERO = 2'h0;
    localparam logic [1:0] TMQ_ROT_90 = 2'h1;
    localparam logic [1:0] TMQ_ROT_180 = 2'h3;
    localparam logic [1:0] TMQ_ROT_270 = 2'h2;
    localparam logic [7:0] TMQ_IDLE_BYTE = 8'h00;
    typedef enum logic [1:0] {TMQ_PH_IDLE, TMQ_PH_TRAIN, TMQ_PH_SYNC, TMQ_PH_ANALYSIS} tmq_phase_e;
    typedef enum logic [2:0] {TMQ_MS_IDLE, TMQ_MS_CODE, TMQ_MS_COUNT, TMQ_MS_GROUP,
        TMQ_MS_TAIL_HI, TMQ_MS_TAIL_LO} tmq_msg_e;
endpackage : tmq_pkg

// >>> logic/tmq_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module tmq_fifo
    import tmq_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    // Full and empty come straight from the occupancy count
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];

    // Storage writes need no reset
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end

    // Pointers wrap by power-of-two depth
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : tmq_fifo

// >>> logic/tmq_scrambler.sv
// Quadrant scrambler bit generator, two bits per step
`timescale 1ns/1ps
module tmq_scrambler
    import tmq_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_reload,
    input wire logic i_step,
    output logic [1:0] o_bits
);
    logic [TMQ_LFSR_W-1:0] state;
    // state[k] holds bit d(n-1-k); two new bits per step
    wire bit0 = state[TMQ_TAP_A] ^ state[TMQ_TAP_B];
    wire bit1 = state[TMQ_TAP_A-1] ^ state[TMQ_TAP_B-1];
    wire [TMQ_LFSR_W-1:0] next_state = {state[TMQ_LFSR_W-3:0], bit0, bit1};

    // Bits go out first-generated in bit 0 for pair (b2j, b2j+1)
    assign o_bits = {bit1, bit0};

    // Reload to all ones wins over stepping
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state <= TMQ_LFSR_SEED;
        else if (i_reload)
            state <= TMQ_LFSR_SEED;
        else if (i_step)
            state <= next_state;
    end
endmodule : tmq_scrambler

// >>> sim/tmq_train_tx_props.sv
// Port-level assertions for the training transmitter
`timescale 1ns/1ps
module tmq_train_tx_props
    import tmq_pkg::*;
#(
    parameter int N_TONES = 64
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_train_start,
    input wire logic i_sync_start,
    input wire logic i_analysis_start,
    input wire logic i_upd_send,
    input wire logic i_upd_repeat,
    input wire logic i_fin_send,
    input wire logic i_fin_repeat,
    input wire logic [15:0] i_fin_ce_len,
    input wire logic [15:0] i_init_ce_len,
    input wire logic i_tone_ready,
    input wire logic o_tone_valid,
    input wire logic [TMQ_TONE_W-1:0] o_tone_idx,
    input wire logic o_tone_x_neg,
    input wire logic o_tone_y_neg,
    input wire logic o_sym_last,
    input wire logic o_msg_busy,
    input wire logic [1:0] o_phase,
    input wire logic [15:0] o_ce_len
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    logic [15:0] fin_len;
    // Update wins a tie, so only a lone extension request latches its length
    wire msg_req = i_upd_send || i_upd_repeat || i_fin_send || i_fin_repeat;
    wire fin_take = (i_fin_send || i_fin_repeat) && !i_upd_send && !i_upd_repeat
        && o_phase == 2'h1 && !o_msg_busy;
    // Shadow of the final extension length the design should apply later
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            fin_len <= 16'h0000;
        else if (fin_take)
            fin_len <= i_fin_ce_len;
    end
    chk_last_tone_idx: assert property (o_sym_last |-> o_tone_valid && o_tone_idx == N_TONES - 1)
        else $error("symbol end flag not on last tone");
    chk_idx_step: assert property (o_tone_valid && i_tone_ready && !o_sym_last |=>
        o_tone_valid && o_tone_idx == $past(o_tone_idx) + 12'h001)
        else $error("tone index did not advance by one");
    // Ready gates the launch, so a stalled cycle must not put out a tone
    chk_stall_hold: assert property (!i_tone_ready |=> !o_tone_valid)
        else $error("tone sent while consumer stalled");
    chk_dc_unrotated: assert property (o_tone_valid && o_tone_idx == 12'h000 |->
        !o_tone_x_neg && !o_tone_y_neg)
        else $error("tone zero was rotated");
    chk_msg_accept: assert property (o_phase == 2'h1 && !o_msg_busy && msg_req |=> o_msg_busy)
        else $error("message request not taken");
    chk_msg_refuse: assert property (msg_req && o_phase != 2'h1 && !o_msg_busy && !i_train_start
        |=> !o_msg_busy)
        else $error("message taken outside training");
    chk_train_enter: assert property (i_train_start && o_phase == 2'h0 |=>
        o_phase == 2'h1 && o_ce_len == $past(i_init_ce_len))
        else $error("training entry wrong");
    chk_sync_enter: assert property (i_sync_start && o_phase == 2'h1 |=> o_phase == 2'h2)
        else $error("sync phase not entered");
    chk_final_ce: assert property (i_analysis_start && o_phase == 2'h2 |=>
        o_phase == 2'h3 && o_ce_len == fin_len)
        else $error("final extension not applied");
    chk_last_pulse: assert property (o_sym_last && i_tone_ready |=> !o_sym_last)
        else $error("symbol end flag held");
    cov_sym_end: cover property (o_sym_last && i_tone_ready);
    cov_stall: cover property (o_tone_valid && !i_tone_ready);
    cov_analysis: cover property (o_phase == 2'h3 && o_tone_valid);
endmodule : tmq_train_tx_props

bind tmq_train_tx tmq_train_tx_props #(.N_TONES(N_TONES)) tmq_train_tx_props_inst (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_train_start(i_train_start),
    .i_sync_start(i_sync_start), .i_analysis_start(i_analysis_start),
    .i_upd_send(i_upd_send), .i_upd_repeat(i_upd_repeat), .i_fin_send(i_fin_send),
    .i_fin_repeat(i_fin_repeat), .i_fin_ce_len(i_fin_ce_len), .i_init_ce_len(i_init_ce_len),
    .i_tone_ready(i_tone_ready), .o_tone_valid(o_tone_valid), .o_tone_idx(o_tone_idx),
    .o_tone_x_neg(o_tone_x_neg), .o_tone_y_neg(o_tone_y_neg), .o_sym_last(o_sym_last),
    .o_msg_busy(o_msg_busy), .o_phase(o_phase), .o_ce_len(o_ce_len));

// >>> sim/tmq_remote_sink.sv
// Far-end tone consumer that records each symbol's points
`timescale 1ns/1ps
module tmq_remote_sink #(
    parameter int N = 20
)
(
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_valid,
    input wire logic [11:0] i_idx,
    input wire logic i_x_neg,
    input wire logic i_y_neg,
    input wire logic i_last,
    output logic o_ready
);
    logic [1:0] cnt = 2'h0;
    logic xs [0:N-1];
    logic ys [0:N-1];
    int sym_count = 0;
    initial o_ready = 1'b1;
    // Slow mode drops ready one cycle in three, so the walk must stall cleanly
    always @(posedge i_clk)
    begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        o_ready <= !i_slow || (cnt != 2'h1);
        // Each tone stands one cycle after ready was seen, so every valid tone is taken
        if (i_valid)
        begin
            xs[i_idx] <= i_x_neg;
            ys[i_idx] <= i_y_neg;
            if (i_last)
                sym_count <= sym_count + 1;
        end
    end
endmodule : tmq_remote_sink

// >>> sim/tb_top.sv
// Self-checking bench for the training transmitter
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    import tmq_pkg::*;
    localparam int NT = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic trn = 0, syn = 0, ana = 0, usend = 0, urep = 0, fsend = 0, frep = 0, sym = 0, slow = 0;
    logic [4:0] ucnt = 5'h0;
    logic [191:0] utones = '0;
    logic [191:0] ugains = '0;
    logic [15:0] uadv = 16'h0000, flen = 16'h0000, ilen = 16'h0000;
    logic vld, xn, yn, last, busy, rdy;
    logic [11:0] idx;
    logic [1:0] ph;
    logic [15:0] ce;
    int fail_count = 0, checks_done = 0, cycles = 0;
    logic sb [0:4*NT+16];

    tmq_train_tx #(.N_TONES(NT)) tmq_train_tx_inst (.i_ref_clk(clk), .i_rst_b(rst_b),
        .i_train_start(trn), .i_sync_start(syn), .i_analysis_start(ana), .i_upd_send(usend),
        .i_upd_repeat(urep), .i_upd_count(ucnt), .i_upd_tones(utones), .i_upd_gains(ugains),
        .i_upd_timing_adv(uadv), .i_fin_send(fsend), .i_fin_repeat(frep), .i_fin_ce_len(flen),
        .i_init_ce_len(ilen), .i_sym_start(sym), .i_tone_ready(rdy), .o_tone_valid(vld),
        .o_tone_idx(idx), .o_tone_x_neg(xn), .o_tone_y_neg(yn), .o_sym_last(last),
        .o_msg_busy(busy), .o_phase(ph), .o_ce_len(ce));
    tmq_remote_sink #(.N(NT)) tmq_remote_sink_inst (.i_clk(clk), .i_slow(slow), .i_valid(vld),
        .i_idx(idx), .i_x_neg(xn), .i_y_neg(yn), .i_last(last), .o_ready(rdy));

    initial forever #50 clk = ~clk;

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // A run far beyond the planned symbol count means a hang
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic pulse(ref logic s);
        @(negedge clk) s = 1'b1;
        @(negedge clk) s = 1'b0;
    endtask : pulse

    // Expected sign pair of tone j carrying byte b, scrambler bits from offset off
    function automatic logic [1:0] exp_pt(input logic [7:0] b, input int j, input int off);
        logic x;
        logic y;
        int s;
        s = j % 10;
        x = 1'b0;
        y = 1'b0;
        if (s == 1 || s == 3 || s == 5 || s == 7)
        begin
            x = b[s-1];
            y = b[s];
        end
        if (j != 0)
            case ({sb[off+2*j], sb[off+2*j+1]})
                2'b01: {x, y} = {!y, x};
                2'b11: {x, y} = {!x, !y};
                2'b10: {x, y} = {y, !x};
                default: ;
            endcase
        return {x, y};
    endfunction : exp_pt

    // In analysis the data tones carry the idle byte, yet only even tones and the pad tone are judged
    task automatic run_sym(input logic [7:0] b, input int off, input bit am);
        int k;
        int n0;
        n0 = tmq_remote_sink_inst.sym_count;
        k = 0;
        pulse(sym);
        while (tmq_remote_sink_inst.sym_count == n0 && k < 300)
        begin
            @(negedge clk);
            k++;
        end
        `CHK(k < 300, 1'b1)
        repeat (4) @(negedge clk);
        for (int j = 0; j < NT; j++)
            if (!am || j % 2 == 0 || j % 10 == 9)
                `CHK({tmq_remote_sink_inst.xs[j], tmq_remote_sink_inst.ys[j]}, exp_pt(b, j, off))
    endtask : run_sym

    task t_idle;
        `CHK(ph, 2'h0)
        `CHK(vld, 1'b0)
        pulse(usend);
        @(negedge clk);
        `CHK(busy, 1'b0)
        $display("test idle done");
    endtask : t_idle

    task t_train;
        ilen = 16'h0028;
        pulse(trn);
        @(negedge clk);
        `CHK(ph, 2'h1)
        `CHK(ce, 16'h0028)
        run_sym(8'h00, 0, 0);
        slow = 1'b1;
        run_sym(8'h00, 0, 0);
        slow = 1'b0;
        $display("test train done");
    endtask : t_train

    task automatic t_update;
        logic [7:0] eb [0:9];
        utones[23:0] = {12'h0a3, 12'h400};
        ugains[23:0] = {12'hff8, 12'h030};
        ucnt = 5'h2;
        uadv = 16'hfffe;
        eb[0] = 8'h5a;
        eb[1] = 8'h02;
        {eb[4], eb[3], eb[2]} = {12'h030, 12'h400};
        {eb[7], eb[6], eb[5]} = {12'hff8, 12'h0a3};
        {eb[9], eb[8]} = uadv;
        pulse(usend);
        repeat (6) @(negedge clk);
        `CHK(busy, 1'b1)
        for (int i = 0; i < 10; i++)
            run_sym(eb[i], 0, 0);
        run_sym(8'h00, 0, 0);
        `CHK(busy, 1'b0)
        pulse(urep);
        repeat (6) @(negedge clk);
        for (int i = 0; i < 10; i++)
            run_sym(eb[i], 0, 0);
        run_sym(8'h00, 0, 0);
        $display("test update done");
    endtask : t_update

    task fin3;
        repeat (3) @(negedge clk);
        run_sym(8'ha5, 0, 0);
        run_sym(8'hc3, 0, 0);
        run_sym(8'h01, 0, 0);
    endtask : fin3

    task t_final;
        flen = 16'h01c3;
        pulse(fsend);
        fin3();
        run_sym(8'h00, 0, 0);
        pulse(frep);
        fin3();
        $display("test final done");
    endtask : t_final

    task t_analysis;
        pulse(syn);
        @(negedge clk);
        `CHK(ph, 2'h2)
        pulse(ana);
        @(negedge clk);
        `CHK(ph, 2'h3)
        `CHK(ce, 16'h01c3)
        run_sym(8'h00, 0, 1);
        run_sym(8'h00, 2 * NT + 4, 1);
        $display("test analysis done");
    endtask : t_analysis

    // Reference scrambler stream, history before the first bit is all ones
    initial
    begin
        for (int n = 0; n <= 4 * NT + 16; n++)
            sb[n] = (n < 9 ? 1'b1 : sb[n-9]) ^ (n < 11 ? 1'b1 : sb[n-11]);
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        t_idle();
        t_train();
        t_update();
        t_final();
        t_analysis();
        print_verdict();
    end
endmodule : tb_top
